// *** hw/loop_ctrl_defs.vh ***
// Constants for the hardware loop controller.
`ifndef LOOP_CTRL_DEFS_VH
`define LOOP_CTRL_DEFS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ADDR_CMD 4'h0
`define ADDR_OPERAND 4'h4
`define ADDR_END 4'h8
`define ADDR_STATUS 4'hC

// ----------------------------------------
// Command field positions
// ----------------------------------------
`define CMD_START_BIT 0
`define CMD_FOREVER_BIT 1
`define CMD_SRC_LSB 2
`define CMD_SRC_MSB 3
`define CMD_STEP_BIT 4
`define CMD_TERM_BIT 5
`define CMD_COMPAT_BIT 6

// ----------------------------------------
// Count sources
// ----------------------------------------
`define SRC_OPERAND 2'h0
`define SRC_SHORT 2'h1
`define SRC_SP 2'h2
`define SRC_STACK_LOW 2'h3

// ----------------------------------------
// Status field positions, reset values and the compat count
// ----------------------------------------
`define STAT_ACTIVE_BIT 15
`define STAT_FOREVER_BIT 16
`define STAT_COMPAT_BIT 13
`define RST_WORD 24'h000000
`define RST_SP 4'h0
`define COMPAT_ITER 17'h10000

`endif

// *** hw/loop_stack.v ***
// System stack of sixteen entries, each holding a high and a low word.
`timescale 1ns/1ps
`include "loop_ctrl_defs.vh"
module loop_stack (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write port
    input wire wr_en,
    input wire [3:0] wr_idx,
    input wire [23:0] wr_high,
    input wire [23:0] wr_low,
    // Read ports
    input wire [3:0] rd_idx,
    output wire [23:0] rd_high,
    output wire [23:0] rd_low,
    output wire [23:0] below_high,
    output wire [23:0] below_low
);
    reg [23:0] high_ff [0:15];
    reg [23:0] low_ff [0:15];
    integer i;

    always @(posedge aclk) begin
        if (!aresetn) begin
            for (i = 0; i < 16; i = i + 1) begin
                high_ff[i] <= `RST_WORD;
                low_ff[i] <= `RST_WORD;
            end
        end else if (wr_en) begin
            high_ff[wr_idx] <= wr_high;
            low_ff[wr_idx] <= wr_low;
        end
    end

    assign rd_high = high_ff[rd_idx];
    assign rd_low = low_ff[rd_idx];
    assign below_high = high_ff[rd_idx - 4'h1];
    assign below_low = low_ff[rd_idx - 4'h1];
endmodule

// *** hw/axil_slave.v ***
// AXI4-Lite slave front end: captures one write and one read at a time.
`timescale 1ns/1ps
module axil_slave (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write channels
    input wire [3:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // Read channels
    input wire [3:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // Register side
    output reg wr_pulse,
    output reg [3:0] wr_addr,
    output reg [31:0] wr_data,
    input wire [31:0] rd_value,
    output wire [3:0] rd_addr,
    input wire wr_mapped
);
    reg aw_have_ff;
    reg w_have_ff;

    assign rd_addr = araddr;

    // ----------------------------------------
    // Write path
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            wr_pulse <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 32'h00000000;
        end else begin
            wr_pulse <= 1'b0;
            if (awvalid && awready) begin
                wr_addr <= awaddr;
                aw_have_ff <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wr_data <= wdata;
                w_have_ff <= 1'b1;
                wready <= 1'b0;
            end
            if (aw_have_ff && w_have_ff && !bvalid) begin
                // Partial strobes are treated as a full word write.
                wr_pulse <= 1'b1;
                bvalid <= 1'b1;
                bresp <= wr_mapped ? 2'h0 : 2'h2;
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_value;
                rresp <= (araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule

// *** hw/hardware_loop_controller.v ***
// Zero-overhead hardware loop sequencer with its system stack and bus slave.
`timescale 1ns/1ps
`include "loop_ctrl_defs.vh"

module hardware_loop_controller (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Fetch side
    output reg [23:0] fetch_pc_ff,
    output reg loop_active_flag_ff,
    output reg infinite_loop_flag_ff
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_PUSH2 = 4'b0010;
    localparam ST_ARM = 4'b0100;
    localparam ST_SKIP = 4'b1000;

    reg [3:0] state_ff;
    reg [23:0] loop_end_address_ff;
    reg [23:0] loop_iteration_count_ff;
    reg [3:0] stack_pointer_reg_ff;
    reg [23:0] status_register_reg_ff;
    reg [23:0] operand_ff;
    reg [23:0] ext_word_ff;
    reg forever_ff;
    reg [1:0] src_ff;

    wire wr_pulse;
    wire [3:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] rd_addr;
    reg [31:0] rd_value;
    wire wr_mapped;

    reg stk_wr;
    reg [3:0] stk_idx;
    reg [23:0] stk_high;
    reg [23:0] stk_low;
    wire [23:0] stack_top_high_word;
    wire [23:0] stack_top_low_word;
    wire [23:0] below_high;
    wire [23:0] below_low;

    wire cmd_wr;
    wire start_req;
    wire step_req;
    wire term_req;
    wire at_end;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [3:0] sp_step;
        input [3:0] sp;
        input [3:0] delta;
        begin
            sp_step = sp + delta;
        end
    endfunction

    axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr_pulse(wr_pulse),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_value(rd_value),
        .rd_addr(rd_addr),
        .wr_mapped(wr_mapped)
    );

    loop_stack u_stack (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(stk_wr),
        .wr_idx(stk_idx),
        .wr_high(stk_high),
        .wr_low(stk_low),
        .rd_idx(stack_pointer_reg_ff),
        .rd_high(stack_top_high_word),
        .rd_low(stack_top_low_word),
        .below_high(below_high),
        .below_low(below_low)
    );

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    assign wr_mapped = (wr_addr == `ADDR_CMD) || (wr_addr == `ADDR_OPERAND) ||
                       (wr_addr == `ADDR_END) || (wr_addr == `ADDR_STATUS);
    assign cmd_wr = wr_pulse && (wr_addr == `ADDR_CMD);
    assign start_req = cmd_wr && wr_data[`CMD_START_BIT] && (state_ff == ST_IDLE);
    assign step_req = cmd_wr && wr_data[`CMD_STEP_BIT] && (state_ff == ST_IDLE);
    assign term_req = cmd_wr && wr_data[`CMD_TERM_BIT] && (state_ff == ST_IDLE);
    assign at_end = loop_active_flag_ff && (fetch_pc_ff == loop_end_address_ff);

    always @* begin
        case (rd_addr)
            `ADDR_CMD: rd_value = {28'h0000000, state_ff};
            `ADDR_OPERAND: rd_value = {8'h00, loop_iteration_count_ff};
            `ADDR_END: rd_value = {8'h00, loop_end_address_ff};
            `ADDR_STATUS: rd_value = {4'h0, stack_pointer_reg_ff, fetch_pc_ff};
            default: rd_value = 32'h00000000;
        endcase
    end

    // ----------------------------------------
    // Stack writes
    // ----------------------------------------
    always @* begin
        stk_wr = 1'b0;
        stk_idx = sp_step(stack_pointer_reg_ff, 4'h1);
        stk_high = loop_end_address_ff;
        stk_low = loop_iteration_count_ff;
        if (start_req) begin
            stk_wr = 1'b1;
        end else if (state_ff == ST_PUSH2) begin
            stk_wr = 1'b1;
            stk_high = fetch_pc_ff;
            stk_low = status_register_reg_ff;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            loop_end_address_ff <= `RST_WORD;
            loop_iteration_count_ff <= `RST_WORD;
            stack_pointer_reg_ff <= `RST_SP;
            status_register_reg_ff <= `RST_WORD;
            operand_ff <= `RST_WORD;
            ext_word_ff <= `RST_WORD;
            fetch_pc_ff <= `RST_WORD;
            forever_ff <= 1'b0;
            src_ff <= `SRC_OPERAND;
            loop_active_flag_ff <= 1'b0;
            infinite_loop_flag_ff <= 1'b0;
        end else begin
            if (wr_pulse && wr_addr == `ADDR_OPERAND) begin
                operand_ff <= wr_data[23:0];
            end
            if (wr_pulse && wr_addr == `ADDR_END) begin
                ext_word_ff <= wr_data[23:0];
            end
            if (wr_pulse && wr_addr == `ADDR_STATUS && state_ff == ST_IDLE) begin
                fetch_pc_ff <= wr_data[23:0];
            end
            if (cmd_wr) begin
                status_register_reg_ff[`STAT_COMPAT_BIT] <= wr_data[`CMD_COMPAT_BIT];
            end
            case (state_ff)
                ST_IDLE: begin
                    if (start_req) begin
                        stack_pointer_reg_ff <= sp_step(stack_pointer_reg_ff, 4'h1);
                        forever_ff <= wr_data[`CMD_FOREVER_BIT];
                        src_ff <= wr_data[`CMD_SRC_MSB:`CMD_SRC_LSB];
                        if (!wr_data[`CMD_FOREVER_BIT]) begin
                            case (wr_data[`CMD_SRC_MSB:`CMD_SRC_LSB])
                                `SRC_SHORT: loop_iteration_count_ff <= {12'h000, operand_ff[11:0]};
                                `SRC_SP: loop_iteration_count_ff <= {20'h00000, sp_step(stack_pointer_reg_ff, 4'h1)};
                                `SRC_STACK_LOW: loop_iteration_count_ff <= loop_iteration_count_ff;
                                default: loop_iteration_count_ff <= operand_ff;
                            endcase
                        end
                        state_ff <= ST_PUSH2;
                    end else if (step_req || term_req) begin
                        if (term_req || (at_end && !infinite_loop_flag_ff &&
                                         loop_iteration_count_ff == 24'h000001)) begin
                            loop_active_flag_ff <= stack_top_low_word[`STAT_ACTIVE_BIT];
                            infinite_loop_flag_ff <= stack_top_low_word[`STAT_FOREVER_BIT];
                            status_register_reg_ff[`STAT_ACTIVE_BIT] <= stack_top_low_word[`STAT_ACTIVE_BIT];
                            status_register_reg_ff[`STAT_FOREVER_BIT] <= stack_top_low_word[`STAT_FOREVER_BIT];
                            loop_end_address_ff <= below_high;
                            loop_iteration_count_ff <= below_low;
                            stack_pointer_reg_ff <= sp_step(stack_pointer_reg_ff, 4'hE);
                            fetch_pc_ff <= fetch_pc_ff + 24'h000001;
                        end else if (at_end) begin
                            loop_iteration_count_ff <= loop_iteration_count_ff - 24'h000001;
                            fetch_pc_ff <= stack_top_high_word;
                        end else begin
                            fetch_pc_ff <= fetch_pc_ff + 24'h000001;
                        end
                    end
                end
                ST_PUSH2: begin
                    stack_pointer_reg_ff <= sp_step(stack_pointer_reg_ff, 4'h1);
                    loop_end_address_ff <= ext_word_ff;
                    // The pushed address is the jump-back target, so fetch must not move past it.
                    state_ff <= ST_ARM;
                end
                ST_ARM: begin
                    // zero count skips unless forever or compat set
                    if (!forever_ff && loop_iteration_count_ff == 24'h000000 &&
                        !status_register_reg_ff[`STAT_COMPAT_BIT]) begin
                        state_ff <= ST_SKIP;
                    end else begin
                        loop_active_flag_ff <= 1'b1;
                        infinite_loop_flag_ff <= forever_ff;
                        status_register_reg_ff[`STAT_ACTIVE_BIT] <= 1'b1;
                        status_register_reg_ff[`STAT_FOREVER_BIT] <= forever_ff;
                        if (!forever_ff && loop_iteration_count_ff == 24'h000000) begin
                            loop_iteration_count_ff <= {7'h00, `COMPAT_ITER};
                        end
                        state_ff <= ST_IDLE;
                    end
                end
                ST_SKIP: begin
                    // skip body: unwind and resume after the end address
                    loop_end_address_ff <= below_high;
                    loop_iteration_count_ff <= below_low;
                    stack_pointer_reg_ff <= sp_step(stack_pointer_reg_ff, 4'hE);
                    fetch_pc_ff <= loop_end_address_ff + 24'h000001;
                    state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule

// *** verification/loop_ctrl_properties.sv ***
// Port checker for the hardware loop controller.
`timescale 1ns/1ps
module loop_ctrl_checker (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [1:0] s_axi_bresp,
    // Fetch side
    input wire [23:0] fetch_pc_ff,
    input wire loop_active_flag_ff,
    input wire infinite_loop_flag_ff
);
    reg [3:0] since_wr_ff;
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    // Saturates so that a long idle spell cannot wrap back into the window.
    always @(posedge aclk) begin
        if (!aresetn || (s_axi_bvalid && s_axi_bready)) begin
            since_wr_ff <= 4'h0;
        end else if (since_wr_ff != 4'hF) begin
            since_wr_ff <= since_wr_ff + 4'h1;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_clears_flags: assert property (disable iff (1'b0)
        !aresetn |=> !loop_active_flag_ff && !infinite_loop_flag_ff) else $error("flags survive reset");
    a_pc_moves_on_cmd: assert property ($changed(fetch_pc_ff) |-> since_wr_ff <= 4'h6)
        else $error("fetch address moved without a command");
    a_flags_move_on_cmd: assert property (
        $changed(loop_active_flag_ff) || $changed(infinite_loop_flag_ff) |-> since_wr_ff <= 4'h6)
        else $error("loop flags moved without a command");
    a_forever_in_loop: assert property ($rose(infinite_loop_flag_ff) |-> loop_active_flag_ff)
        else $error("infinite flag set without active flag");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_rvalid_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    c_forever: cover property ($rose(infinite_loop_flag_ff));
    c_exit: cover property ($fell(loop_active_flag_ff));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind hardware_loop_controller loop_ctrl_checker loop_ctrl_checker_inst (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .fetch_pc_ff, .loop_active_flag_ff,
    .infinite_loop_flag_ff);

// *** verification/fetch_side_model.sv ***
// Fetch-side model that counts passes over a loop body.
`timescale 1ns/1ps
module fetch_side_model (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Fetch view
    input wire [23:0] fetch_pc,
    input wire loop_active,
    // Pass count
    output reg [7:0] passes_ff
);
    reg [23:0] last_pc_ff;
    // refetch each pass
    // A falling fetch address while the loop runs marks a new fetch of the body.
    always @(posedge aclk) begin
        last_pc_ff <= fetch_pc;
        if (!aresetn) begin
            passes_ff <= 8'h00;
        end else if (loop_active && fetch_pc < last_pc_ff) begin
            passes_ff <= passes_ff + 8'h01;
        end
    end
endmodule

// *** verification/tb_hardware_loop_controller.sv ***
// Self-checking bench for the hardware loop controller.
`timescale 1ns/1ps
`include "loop_ctrl_defs.vh"
module tb_hardware_loop_controller;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [23:0] fetch_pc_ff;
    wire loop_active_flag_ff, infinite_loop_flag_ff;
    wire [7:0] passes;
    logic [31:0] rv;
    logic [1:0] resp;
    int errors = 0;
    int cmp_count = 0;
    localparam logic [31:0] cmd_step = 32'h10;
    localparam logic [31:0] cmd_term = 32'h20;

    hardware_loop_controller hardware_loop_controller_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .fetch_pc_ff, .loop_active_flag_ff, .infinite_loop_flag_ff);
    fetch_side_model fetch_side_model_inst (.aclk, .aresetn, .fetch_pc(fetch_pc_ff),
        .loop_active(loop_active_flag_ff), .passes_ff(passes));

    always #4 aclk = ~aclk;
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic flags(input logic [1:0] e);
        chk({30'h0, infinite_loop_flag_ff, loop_active_flag_ff}, {30'h0, e});
    endtask
    // The trailing edge lets the command land before ports are looked at.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        rd(a);
        chk(rv, exp);
    endtask
    task automatic start(input logic [6:0] cmd, input logic [23:0] op, input logic [23:0] top,
            input logic [23:0] last);
        int n;
        n = 0;
        wr(`ADDR_OPERAND, {8'h00, op});
        wr(`ADDR_END, {8'h00, last});
        wr(`ADDR_STATUS, {8'h00, top});
        wr(`ADDR_CMD, {25'h0, cmd});
        do begin
            rd(`ADDR_CMD);
            n++;
        end while (rv !== 32'h1 && n < 20);
    endtask
    task automatic run_pass(input logic [23:0] last);
        int n;
        n = 0;
        while (fetch_pc_ff !== last && n < 20) begin
            wr(`ADDR_CMD, cmd_step);
            n++;
        end
        wr(`ADDR_CMD, cmd_step);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        flags(2'b00);
        rd_chk(`ADDR_STATUS, 32'h0);
        wr(4'h2, 32'h0);
        chk({30'h0, resp}, 32'h2);
        rd(4'h6);
        chk({30'h0, resp}, 32'h2);
    endtask
    task automatic t_counted;
        start(7'h01, 24'h3, 24'h100, 24'h105);
        flags(2'b01);
        rd_chk(`ADDR_OPERAND, 32'h3);
        rd_chk(`ADDR_END, 32'h105);
        rd(`ADDR_STATUS);
        chk({28'h0, rv[27:24]}, 32'h2);
        for (int i = 2; i >= 1; i--) begin
            run_pass(24'h105);
            chk({8'h0, fetch_pc_ff}, 32'h100);
            rd_chk(`ADDR_OPERAND, 32'(i));
        end
        chk({24'h0, passes}, 32'h2);
        run_pass(24'h105);
        flags(2'b00);
        rd_chk(`ADDR_STATUS, 32'h106);
        rd_chk(`ADDR_OPERAND, 32'h0);
        rd_chk(`ADDR_END, 32'h0);
    endtask
    task automatic t_short_zero;
        start(7'h05, 24'hFFFFFF, 24'h010, 24'h020);
        rd_chk(`ADDR_OPERAND, 32'hFFF);
        wr(`ADDR_CMD, cmd_term);
        start(7'h01, 24'h0, 24'h028, 24'h030);
        flags(2'b00);
        rd_chk(`ADDR_STATUS, 32'h31);
        start(7'h41, 24'h0, 24'h028, 24'h030);
        rd_chk(`ADDR_OPERAND, 32'h10000);
        wr(`ADDR_CMD, cmd_term);
    endtask
    task automatic t_idle;
        wr(`ADDR_STATUS, 32'h0);
        wr(`ADDR_CMD, cmd_step);
        chk({8'h0, fetch_pc_ff}, 32'h1);
        rd_chk(`ADDR_OPERAND, 32'h0);
        flags(2'b00);
    endtask
    task automatic t_nested;
        start(7'h01, 24'h1, 24'h180, 24'h1FF);
        start(7'h09, 24'h0, 24'h190, 24'h1F0);
        rd_chk(`ADDR_OPERAND, 32'h3);
        wr(`ADDR_CMD, cmd_term);
        rd_chk(`ADDR_END, 32'h1FF);
        rd_chk(`ADDR_OPERAND, 32'h1);
        flags(2'b01);
        start(7'h0D, 24'h0, 24'h190, 24'h1F0);
        rd_chk(`ADDR_OPERAND, 32'h1);
        wr(`ADDR_CMD, cmd_term);
        start(7'h03, 24'h55, 24'h1EC, 24'h1F0);
        flags(2'b11);
        rd_chk(`ADDR_OPERAND, 32'h1);
        rd(`ADDR_STATUS);
        chk({28'h0, rv[27:24]}, 32'h4);
        run_pass(24'h1F0);
        chk({8'h0, fetch_pc_ff}, 32'h1EC);
        rd_chk(`ADDR_OPERAND, 32'h0);
        wr(`ADDR_CMD, cmd_term);
        wr(`ADDR_CMD, cmd_term);
        chk({31'h0, loop_active_flag_ff}, 32'h0);
    endtask
    task automatic t_mid_reset;
        start(7'h03, 24'h0, 24'h040, 24'h044);
        flags(2'b11);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        flags(2'b00);
        rd_chk(`ADDR_STATUS, 32'h0);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    task automatic end_sim;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_counted;
        t_short_zero;
        t_idle;
        t_nested;
        t_mid_reset;
        end_sim;
    end
    // Generous against a few hundred cycles of traffic.
    initial begin
        #(20000 * 8);
        errors++;
        end_sim;
    end
endmodule
